// file: fspc_pkg.sv
// What this block does
// - command X0000011 then a store within four cycles erases the pointer's page.
// - erase of the shared region keeps boot region readable; boot-region erase halts core.
// - command 00000001 then a store within four cycles loads one buffer word.
// - buffer clears after page write, on section-read-enable write, and at reset.
// - each buffer word location takes only one load between clears.
// - buffer words may be loaded in any order.
// - command X0000101 then a store within four cycles writes the buffer to a page.
// - write to shared region keeps boot region readable; boot-region write halts core.
// - with ready interrupt enabled, request stands while store-enable is clear.
// - during erase or write, shared region reads blocked and busy flag set.
// - command X0001001 then a store within four cycles sets boot lock bits.
// - zeros in data bits 5..2 program matching boot lock bits; pointer ignored.
// - whole flash stays readable while lock bits are programmed.
// - during eeprom write, refuse all commands and fuse or lock reads.
// - pointer 0001 with lock read set, load within three cycles returns lock byte.
// - lock access and store enable self-clear after read or window expiry.
// - pointer 0000 with read set, load within three cycles returns low fuse byte.
// - pointer 0003 with read set, load within three cycles returns high fuse byte.
// - page field is pointer bits 14..7, word field 6..1, bit 15 ignored.
// - store enable stays set through erase or write, clearing signals ready.
// - only the five listed low command codes act; others do nothing.
package fspc_pkg;

  // timing
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint PROG_TIME_US = 3700;
  localparam longint PROG_CYCLES =
    (PROG_TIME_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;

  // register map
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam int CMD_IRQ_EN_BIT = 7;
  localparam int CMD_BUSY_BIT = 6;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // low five command codes
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_RSE = 5'h11;
  localparam logic [4:0] CODE_LOCK = 5'h09;
  localparam logic [4:0] CODE_WRITE = 5'h05;
  localparam logic [4:0] CODE_ERASE = 5'h03;
  localparam logic [4:0] CODE_LOAD = 5'h01;

  // pointer fields
  localparam int PAGE_MSB = 14;
  localparam int PAGE_LSB = 7;
  localparam int WORD_MSB = 6;
  localparam int WORD_LSB = 1;
  localparam logic [7:0] HALT_FIRST_PAGE = 8'he0;
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

  // lock byte
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam int LOCK_BOOT_MSB = 5;
  localparam int LOCK_BOOT_LSB = 2;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_PROG = 4'b0100,
    ST_LOCK = 4'b1000
  } fspc_state_t;

  typedef struct packed {
    logic start;
    logic erase;
    logic [7:0] page;
  } fspc_prog_t;

endpackage : fspc_pkg

// file: fspc_top.sv
module fspc_top #(
  parameter int PAGE_WORDS = 64,
  parameter int WORD_W = 16,
  parameter int unsigned PROG_CYCLES = 32'(fspc_pkg::PROG_CYCLES)
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // core side: store and load instructions
  input wire logic i_store,
  input wire logic i_load,
  input wire logic [15:0] i_ptr,
  input wire logic [7:0] i_data_lo,
  input wire logic [7:0] i_data_hi,
  output logic o_load_hit,
  output logic [7:0] o_load_data,
  output logic o_cpu_halt,
  output logic o_section_busy,
  output logic o_irq,
  // fuses and eeprom status
  input wire logic [7:0] i_fuse_low,
  input wire logic [7:0] i_fuse_high,
  input wire logic i_eeprom_busy,
  // flash array side
  output fspc_pkg::fspc_prog_t o_prog,
  output logic o_prog_active,
  input wire logic [$clog2(PAGE_WORDS)-1:0] i_buf_idx,
  output logic [WORD_W-1:0] o_buf_word
);

  localparam int IDX_W = $clog2(PAGE_WORDS);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PROG_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // reset release
  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  fspc_pkg::fspc_state_t state_reg;
  fspc_pkg::fspc_state_t state_next;
  logic [4:0] code_reg;
  logic [2:0] arm_cnt_reg;
  logic [CNT_W-1:0] prog_cnt_reg;
  logic irq_en_reg;
  logic busy_reg;
  logic [7:0] page_reg;
  logic [7:0] lock_reg;
  logic [7:0] lock_data_reg;
  logic [PAGE_WORDS-1:0] loaded_reg;
  logic [WORD_W-1:0] buf_mem [PAGE_WORDS];

  logic cmd_wr;
  logic code_ok;
  logic cmd_take;
  logic store_go;
  logic page_op;
  logic op_done;
  logic lock_read;
  logic buf_clear;
  logic [IDX_W-1:0] word_idx;
  logic [7:0] ptr_page;
  logic [4:0] code_vis;

  assign cmd_wr = i_wr && (i_addr == fspc_pkg::CMD_OFS);
  assign code_ok = (i_wdata[4:0] == fspc_pkg::CODE_RSE) ||
                   (i_wdata[4:0] == fspc_pkg::CODE_LOCK) ||
                   (i_wdata[4:0] == fspc_pkg::CODE_WRITE) ||
                   (i_wdata[4:0] == fspc_pkg::CODE_ERASE) ||
                   (i_wdata[4:0] == fspc_pkg::CODE_LOAD);
  // a busy array ignores new codes, so section-read-enable cannot cut an operation short
  assign cmd_take = cmd_wr && code_ok && !i_eeprom_busy &&
                    (state_reg == fspc_pkg::ST_IDLE || state_reg == fspc_pkg::ST_ARMED);
  assign store_go = i_store && (state_reg == fspc_pkg::ST_ARMED);
  assign page_op = (code_reg == fspc_pkg::CODE_ERASE) || (code_reg == fspc_pkg::CODE_WRITE);
  assign op_done = (state_reg == fspc_pkg::ST_PROG || state_reg == fspc_pkg::ST_LOCK) &&
                   (prog_cnt_reg == CNT_ZERO);
  // three-cycle read window is the first three of the four armed cycles
  assign lock_read = i_load && (state_reg == fspc_pkg::ST_ARMED) &&
                     (code_reg == fspc_pkg::CODE_LOCK) && !i_eeprom_busy &&
                     (arm_cnt_reg > (fspc_pkg::STORE_WINDOW - fspc_pkg::LOAD_WINDOW));
  assign word_idx = IDX_W'(i_ptr[fspc_pkg::WORD_MSB:fspc_pkg::WORD_LSB]);
  assign ptr_page = i_ptr[fspc_pkg::PAGE_MSB:fspc_pkg::PAGE_LSB];
  assign buf_clear = (op_done && code_reg == fspc_pkg::CODE_WRITE) ||
                     (cmd_take && i_wdata[4:0] == fspc_pkg::CODE_RSE);
  assign code_vis = (state_reg == fspc_pkg::ST_IDLE) ? fspc_pkg::CODE_NONE : code_reg;

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fspc_pkg::ST_IDLE: begin
        if (cmd_take) begin
          state_next = fspc_pkg::ST_ARMED;
        end
      end
      fspc_pkg::ST_ARMED: begin
        if (store_go) begin
          if (page_op) begin
            state_next = fspc_pkg::ST_PROG;
          end else if (code_reg == fspc_pkg::CODE_LOCK) begin
            state_next = fspc_pkg::ST_LOCK;
          end else begin
            state_next = fspc_pkg::ST_IDLE;
          end
        end else if (lock_read) begin
          state_next = fspc_pkg::ST_IDLE;
        end else if (cmd_take) begin
          state_next = fspc_pkg::ST_ARMED;
        end else if (arm_cnt_reg == 3'h1) begin
          state_next = fspc_pkg::ST_IDLE;
        end
      end
      fspc_pkg::ST_PROG, fspc_pkg::ST_LOCK: begin
        if (op_done) begin
          state_next = fspc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = fspc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fspc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // command code and store window
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= fspc_pkg::CODE_NONE;
      arm_cnt_reg <= 3'h0;
    end else if (cmd_take && !store_go) begin
      code_reg <= i_wdata[4:0];
      arm_cnt_reg <= fspc_pkg::STORE_WINDOW;
    end else if (state_next == fspc_pkg::ST_IDLE) begin
      code_reg <= fspc_pkg::CODE_NONE;
      arm_cnt_reg <= 3'h0;
    end else if (state_reg == fspc_pkg::ST_ARMED) begin
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
    end
  end

  // operation timer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_cnt_reg <= CNT_ZERO;
    end else if (store_go) begin
      prog_cnt_reg <= CNT_LOAD;
    end else if (prog_cnt_reg != CNT_ZERO) begin
      prog_cnt_reg <= prog_cnt_reg - CNT_W'(1);
    end
  end

  // interrupt enable bit, stored on any command register write
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= fspc_pkg::CMD_RESET[fspc_pkg::CMD_IRQ_EN_BIT];
    end else if (cmd_wr) begin
      irq_en_reg <= i_wdata[fspc_pkg::CMD_IRQ_EN_BIT];
    end
  end

  // busy flag: set by erase or write, cleared by section-read-enable or a word load
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else if (store_go && page_op) begin
      busy_reg <= 1'b1;
    end else if (store_go && (code_reg == fspc_pkg::CODE_RSE ||
                              code_reg == fspc_pkg::CODE_LOAD)) begin
      busy_reg <= 1'b0;
    end
  end

  // latched page address, free pointer afterwards
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= 8'h00;
    end else if (store_go && page_op) begin
      page_reg <= ptr_page;
    end
  end

  // flash array request
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_prog <= '0;
    end else begin
      o_prog.start <= store_go && page_op;
      if (store_go && page_op) begin
        o_prog.erase <= (code_reg == fspc_pkg::CODE_ERASE);
        o_prog.page <= ptr_page;
      end
    end
  end

  // boot lock bits
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_data_reg <= 8'hff;
    end else if (store_go && code_reg == fspc_pkg::CODE_LOCK) begin
      lock_data_reg <= i_data_lo;
    end
  end

  // lock bits only ever go from one to zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= fspc_pkg::LOCK_RESET;
    end else if (op_done && state_reg == fspc_pkg::ST_LOCK) begin
      lock_reg[fspc_pkg::LOCK_BOOT_MSB:fspc_pkg::LOCK_BOOT_LSB] <=
        lock_reg[fspc_pkg::LOCK_BOOT_MSB:fspc_pkg::LOCK_BOOT_LSB] &
        lock_data_reg[fspc_pkg::LOCK_BOOT_MSB:fspc_pkg::LOCK_BOOT_LSB];
    end
  end

  // temporary page buffer occupancy
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_reg <= '0;
    end else if (buf_clear) begin
      loaded_reg <= '0;
    end else if (store_go && code_reg == fspc_pkg::CODE_LOAD) begin
      loaded_reg[word_idx] <= 1'b1;
    end
  end

  // data words carry no reset; an empty location reads as erased
  always_ff @(posedge i_clk) begin
    if (store_go && code_reg == fspc_pkg::CODE_LOAD && !loaded_reg[word_idx]) begin
      buf_mem[word_idx] <= WORD_W'({i_data_hi, i_data_lo});
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_buf_word <= '1;
    end else if (loaded_reg[i_buf_idx]) begin
      o_buf_word <= buf_mem[i_buf_idx];
    end else begin
      o_buf_word <= '1;
    end
  end

  // fuse and lock read answer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_load_hit <= 1'b0;
      o_load_data <= 8'hff;
    end else begin
      o_load_hit <= lock_read;
      if (lock_read) begin
        case (i_ptr)
          fspc_pkg::PTR_LOCK: o_load_data <= lock_reg;
          fspc_pkg::PTR_FUSE_LOW: o_load_data <= i_fuse_low;
          fspc_pkg::PTR_FUSE_HIGH: o_load_data <= i_fuse_high;
          default: o_load_data <= 8'hff;
        endcase
      end
    end
  end

  // register read, one cycle later
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd && i_addr == fspc_pkg::CMD_OFS) begin
      o_rdata <= {irq_en_reg, busy_reg, 1'b0, code_vis};
    end else if (i_rd) begin
      o_rdata <= fspc_pkg::UNMAPPED_READ;
    end
  end

  // lock programming blocks nothing; only page operations on boot pages halt
  assign o_cpu_halt = (state_reg == fspc_pkg::ST_PROG) &&
                      (page_reg >= fspc_pkg::HALT_FIRST_PAGE);
  assign o_section_busy = busy_reg;
  assign o_prog_active = (state_reg == fspc_pkg::ST_PROG);
  assign o_irq = irq_en_reg && (state_reg == fspc_pkg::ST_IDLE);

endmodule : fspc_top

// file: fspc_top_sva.sv
module fspc_top_sva #(
  parameter int unsigned PROG_CYCLES = 32'(fspc_pkg::PROG_CYCLES)
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // core side
  input wire logic i_wr,
  input wire logic i_store,
  input wire logic i_load,
  input wire logic i_eeprom_busy,
  // results
  input wire fspc_pkg::fspc_prog_t o_prog,
  input wire logic o_prog_active,
  input wire logic o_cpu_halt,
  input wire logic o_section_busy,
  input wire logic o_irq,
  input wire logic o_load_hit
);
  logic [31:0] run_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // length of the running page operation, checked when it ends
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_cnt <= 32'h0;
    end else begin
      run_cnt <= o_prog_active ? run_cnt + 32'h1 : 32'h0;
    end
  end

  busy_start_a: assert property (o_prog.start |-> o_section_busy && o_prog_active)
    else $error("page operation started without busy");
  halt_region_a: assert property (
    o_prog.start |-> o_cpu_halt == (o_prog.page >= fspc_pkg::HALT_FIRST_PAGE))
    else $error("halt does not match the target region");
  halt_scope_a: assert property (o_cpu_halt |-> o_prog_active)
    else $error("core halted outside a page operation");
  busy_hold_a: assert property (o_prog_active |-> o_section_busy && !o_irq)
    else $error("busy dropped or ready request during operation");
  run_len_a: assert property ($fell(o_prog_active) |-> run_cnt == PROG_CYCLES)
    else $error("page operation length wrong");
  start_cause_a: assert property (o_prog.start |-> $past(i_store) ##1 !o_prog.start)
    else $error("operation start without store or too long");
  ee_block_a: assert property (i_wr && i_eeprom_busy |=> !o_prog.start [*5])
    else $error("command taken during eeprom write");
  load_cause_a: assert property (
    o_load_hit |-> $past(i_load) && !$past(i_eeprom_busy))
    else $error("readback without a permitted load");
endmodule : fspc_top_sva

bind fspc_top fspc_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_fspc_top_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_store(i_store), .i_load(i_load),
  .i_eeprom_busy(i_eeprom_busy), .o_prog(o_prog), .o_prog_active(o_prog_active),
  .o_cpu_halt(o_cpu_halt), .o_section_busy(o_section_busy), .o_irq(o_irq),
  .o_load_hit(o_load_hit));

// file: fspc_core_model.sv
module fspc_core_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request from the bench
  input wire logic i_go,
  input wire logic i_is_load,
  input wire logic [2:0] i_dly,
  // instruction pulses
  output logic o_store,
  output logic o_load
);
  logic [2:0] cnt_reg;
  logic armed_reg;
  logic kind_reg;

  // the instruction lands i_dly cycles after the first legal cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 3'h0;
      armed_reg <= 1'b0;
      kind_reg <= 1'b0;
      o_store <= 1'b0;
      o_load <= 1'b0;
    end else if (i_go && i_dly == 3'h0) begin
      o_store <= !i_is_load;
      o_load <= i_is_load;
    end else if (i_go) begin
      cnt_reg <= i_dly - 3'h1;
      kind_reg <= i_is_load;
      armed_reg <= 1'b1;
    end else if (armed_reg && cnt_reg == 3'h0) begin
      o_store <= !kind_reg;
      o_load <= kind_reg;
      armed_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg - 3'h1;
      o_store <= 1'b0;
      o_load <= 1'b0;
    end
  end
endmodule : fspc_core_model

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 8;
  logic clk, rst_n, wr, rd, go, is_ld, store, load, hit, halt, blk, irq, pact, eeb, rd_d;
  logic [2:0] dly;
  logic [7:0] addr, wdata, dlo, dhi, fl, fh, rdata, ld_data;
  logic [15:0] ptr, bw, seed;
  logic [15:0] wexp[2];
  logic [5:0] bidx;
  fspc_pkg::fspc_prog_t prog;
  int n_fail, num_checks;
  logic [15:0] q_rd[$], q_ld[$], q_pg[$];

  fspc_top #(.PROG_CYCLES(P)) u_fspc_top (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_store(store), .i_load(load),
    .i_ptr(ptr), .i_data_lo(dlo), .i_data_hi(dhi), .o_load_hit(hit), .o_load_data(ld_data),
    .o_cpu_halt(halt), .o_section_busy(blk), .o_irq(irq), .i_fuse_low(fl), .i_fuse_high(fh),
    .i_eeprom_busy(eeb), .o_prog(prog), .o_prog_active(pact), .i_buf_idx(bidx),
    .o_buf_word(bw));
  fspc_core_model u_fspc_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_go(go),
    .i_is_load(is_ld), .i_dly(dly), .o_store(store), .o_load(load));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic finish_test();
    // a note that never found its result is a miss as well
    n_fail += q_rd.size() + q_ld.size() + q_pg.size();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // command write, then the core issues its instruction d cycles late
  task automatic op(input logic [7:0] c, input logic l, input logic [2:0] d,
                    input logic [15:0] p, input logic [15:0] w);
    @(posedge clk);
    wr <= 1'b1;
    addr <= 8'h00;
    wdata <= c;
    go <= 1'b1;
    is_ld <= l;
    dly <= d;
    ptr <= p;
    {dhi, dlo} <= w;
    @(posedge clk);
    wr <= 1'b0;
    go <= 1'b0;
    repeat (d + 2) @(posedge clk);
  endtask : op

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    q_rd.push_back({8'h00, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic buf_chk(input logic [5:0] i, input logic [15:0] e);
    @(posedge clk);
    bidx <= i;
    repeat (2) @(posedge clk);
    #1;
    chk(e, bw);
  endtask : buf_chk

  task automatic lv(input logic [3:0] e);
    #1;
    chk({12'h0, e}, {12'h0, pact, irq, halt, blk});
  endtask : lv

  task automatic wait_idle();
    for (int k = 0; k < 64 && pact !== 1'b0; k++) @(posedge clk);
  endtask : wait_idle

  // results are matched to the oldest note of their kind
  always @(posedge clk) begin
    if (rd_d) chk(q_rd.size() > 0 ? q_rd.pop_front() : 16'hdead, {8'h00, rdata});
    if (rst_n && hit !== 1'b0) chk(q_ld.size() > 0 ? q_ld.pop_front() : 16'hdead,
      {8'h00, ld_data});
    if (rst_n && prog.start !== 1'b0) chk(q_pg.size() > 0 ? q_pg.pop_front() : 16'hdead,
      {6'h00, prog});
    rd_d <= rd;
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial begin
    {rst_n, wr, rd, go, is_ld, eeb, dly, addr, wdata, dlo, dhi, ptr, bidx} = '0;
    n_fail = 0;
    num_checks = 0;
    seed = lfsr(16'hef22);
    {fh, fl} = seed;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(8'h00, 8'h00);
    rd_reg(8'h05, 8'h00);
    for (int i = 0; i < 3; i++) begin
      q_ld.push_back({8'h00, i == 0 ? fl : i == 1 ? 8'hff : fh});
      op(8'h09, 1'b1, 3'(i), i == 2 ? 16'h0003 : 16'(i), 16'h0);
    end
    op(8'h09, 1'b1, 3'h3, 16'h0001, 16'h0);
    eeb <= 1'b1;
    op(8'h09, 1'b1, 3'h0, 16'h0001, 16'h0);
    op(8'h03, 1'b0, 3'h0, 16'h0000, 16'h0);
    eeb <= 1'b0;
    op(8'h07, 1'b0, 3'h0, 16'h0000, 16'h0);
    op(8'h03, 1'b0, 3'h5, 16'h0000, 16'h0);
    rd_reg(8'h00, 8'h00);
    op(8'h09, 1'b0, 3'h3, 16'h7fff, 16'h00c3);
    lv(4'h0);
    repeat (P + 4) @(posedge clk);
    q_ld.push_back(16'h00c3);
    op(8'h09, 1'b1, 3'h0, 16'h0001, 16'h0);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      if (i < 2) wexp[i] = seed;
      op(8'h01, 1'b0, 3'(i), {9'h0, i == 1 ? 6'h02 : 6'h05, 1'b0}, seed);
    end
    buf_chk(6'h05, wexp[0]);
    buf_chk(6'h02, wexp[1]);
    buf_chk(6'h07, 16'hffff);
    q_pg.push_back({6'h00, 1'b1, 1'b1, 8'h12});
    op(8'h83, 1'b0, 3'h3, 16'h8900, 16'h0);
    lv(4'h9);
    rd_reg(8'h00, 8'hc3);
    op(8'h91, 1'b0, 3'h0, 16'h0000, 16'h0);
    wait_idle();
    lv(4'h5);
    rd_reg(8'h00, 8'hc0);
    // boot region page: erase, then write the same page
    for (int j = 0; j < 2; j++) begin
      q_pg.push_back({6'h00, 1'b1, j == 0, 8'he5});
      op(j == 0 ? 8'h03 : 8'h05, 1'b0, 3'h0, 16'h7280, 16'h0);
      lv(4'hb);
      wait_idle();
    end
    buf_chk(6'h05, 16'hffff);
    op(8'h11, 1'b0, 3'h2, 16'h0000, 16'h0);
    rd_reg(8'h00, 8'h00);
    op(8'h01, 1'b0, 3'h1, 16'h0006, 16'h1234);
    buf_chk(6'h03, 16'h1234);
    op(8'h11, 1'b0, 3'h0, 16'h0000, 16'h0);
    buf_chk(6'h03, 16'hffff);
    finish_test();
  end
endmodule : tb
